/* File: logic/apm_auto_powerdown_manager.sv */
`timescale 1ns/10ps
`default_nettype none
`include "apm_params.svh"
module apm_auto_powerdown_manager (
    input wire logic clk,
    input wire logic rst,
    input wire logic pld_clock_input,
    input wire logic chip_select_n_pin,
    input wire logic reset_in_pin,
    input wire logic vcc_below_standby,
    input wire logic battery_indicator_route,
    input wire logic ale_in,
    input wire logic mcu_wr,
    input wire logic mcu_rd,
    input wire logic mcu_psen,
    input wire logic [15:0] mcu_addr,
    input wire logic [7:0] mcu_data,
    input wire apm_pkg::apm_sel_t mem_sel_req,
    input wire logic pmr_first_wr,
    input wire logic pmr_second_wr,
    input wire apm_pkg::apm_byte_t pmr_wdata,
    output logic powerdown_flag,
    output apm_pkg::apm_count_t idle_count,
    output apm_pkg::apm_byte_t power_mode_reg_first,
    output apm_pkg::apm_byte_t power_mode_reg_second,
    output logic [15:0] mem_addr,
    output logic [7:0] mem_data,
    output apm_pkg::apm_sel_t mem_sel,
    output logic [15:0] pld_addr,
    output logic [7:0] pld_data,
    output logic pld_array_clk,
    output logic pld_mcell_clk,
    output logic pld_wr,
    output logic pld_rd,
    output logic pld_psen,
    output logic pld_ale,
    output logic pld_turbo_on,
    output logic battery_on_indicator
);
    import apm_pkg::*;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [3:0] pins_s;
    logic pld_clock_input_s;
    logic csn_s;
    logic reset_s;
    logic vbat_s;

    apm_sync #(.WIDTH(4)) u_sync (
        .clk(clk),
        .rst(rst),
        .async_in({vcc_below_standby, reset_in_pin, chip_select_n_pin, pld_clock_input}),
        .sync_out(pins_s)
    );

    assign pld_clock_input_s = pins_s[0];
    assign csn_s = pins_s[1];
    assign reset_s = pins_s[2];
    assign vbat_s = pins_s[3];

    // ----------------------------------------
    // Power mode registers
    // ----------------------------------------
    apm_byte_t pmr_first_reg;
    apm_byte_t pmr_first_next;
    apm_byte_t pmr_second_reg;
    apm_byte_t pmr_second_next;

    assign pmr_first_next = pmr_first_wr ? (pmr_wdata & `APM_PMR_FIRST_MASK) : pmr_first_reg;
    assign pmr_second_next = pmr_second_wr ? (pmr_wdata & `APM_PMR_SECOND_MASK) : pmr_second_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pmr_first_reg <= `APM_PMR_RESET;
            pmr_second_reg <= `APM_PMR_RESET;
        end else begin
            pmr_first_reg <= pmr_first_next;
            pmr_second_reg <= pmr_second_next;
        end
    end

    assign power_mode_reg_first = pmr_first_reg;
    assign power_mode_reg_second = pmr_second_reg;

    // ----------------------------------------
    // Decoded control bits
    // ----------------------------------------
    logic apd_en;
    logic turbo_off;
    logic array_clk_off;
    logic mcell_clk_off;
    logic wr_off;
    logic rd_off;
    logic psen_off;
    logic ale_off;

    assign apd_en = pmr_first_reg[`APM_BIT_APD_EN];
    assign turbo_off = pmr_first_reg[`APM_BIT_TURBO_OFF];
    assign array_clk_off = pmr_first_reg[`APM_BIT_ARRAY_CLK_OFF];
    assign mcell_clk_off = pmr_first_reg[`APM_BIT_MCELL_CLK_OFF];
    assign wr_off = pmr_second_reg[`APM_BIT_WR_OFF];
    assign rd_off = pmr_second_reg[`APM_BIT_RD_OFF];
    assign psen_off = pmr_second_reg[`APM_BIT_PSEN_OFF];
    assign ale_off = pmr_second_reg[`APM_BIT_ALE_OFF];

    // ----------------------------------------
    // Activity detection
    // ----------------------------------------
    logic ale_prev_reg;
    logic pld_clock_input_prev_reg;
    logic ale_edge;
    logic clk_tick;
    logic cs_high;
    logic exit_cond;
    logic count_restart;
    logic count_full;

    assign ale_edge = ale_in ^ ale_prev_reg;
    assign clk_tick = pld_clock_input_s & ~pld_clock_input_prev_reg;
    assign cs_high = csn_s;
    assign exit_cond = ale_edge | ~csn_s | reset_s;
    assign count_restart = ~apd_en | exit_cond;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ale_prev_reg <= 1'b0;
            pld_clock_input_prev_reg <= 1'b0;
        end else begin
            ale_prev_reg <= ale_in;
            pld_clock_input_prev_reg <= pld_clock_input_s;
        end
    end

    apm_idle_counter u_idle (
        .clk(clk),
        .rst(rst),
        .restart(count_restart),
        .tick(clk_tick),
        .count(idle_count),
        .full(count_full)
    );

    // ----------------------------------------
    // Power-down mode
    // ----------------------------------------
    apm_mode_e mode_reg;
    apm_mode_e mode_next;

    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            APM_NORMAL: begin
                if (apd_en && count_full && !exit_cond) begin
                    mode_next = APM_POWERDOWN;
                end
            end
            APM_POWERDOWN: begin
                if (exit_cond || !apd_en) begin
                    mode_next = APM_NORMAL;
                end
            end
            default: begin
                mode_next = APM_NORMAL;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_reg <= APM_NORMAL;
        end else begin
            mode_reg <= mode_next;
        end
    end

    assign powerdown_flag = (mode_reg == APM_POWERDOWN);

    // ----------------------------------------
    // Memory and array bus blocking
    // ----------------------------------------
    logic pd_next;
    logic [15:0] mem_addr_reg;
    logic [7:0] mem_data_reg;
    apm_sel_t mem_sel_reg;
    apm_sel_t mem_sel_next;
    logic [15:0] pld_addr_reg;
    logic [7:0] pld_data_reg;

    assign pd_next = (mode_next == APM_POWERDOWN);
    assign mem_sel_next = (pd_next || cs_high) ? '0 : mem_sel_req;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_addr_reg <= '0;
            mem_data_reg <= '0;
            pld_addr_reg <= '0;
            pld_data_reg <= '0;
        end else if (!pd_next) begin
            mem_addr_reg <= mcu_addr;
            mem_data_reg <= mcu_data;
            pld_addr_reg <= mcu_addr;
            pld_data_reg <= mcu_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_sel_reg <= '0;
        end else begin
            mem_sel_reg <= mem_sel_next;
        end
    end

    assign mem_addr = mem_addr_reg;
    assign mem_data = mem_data_reg;
    assign mem_sel = mem_sel_reg;
    assign pld_addr = pld_addr_reg;
    assign pld_data = pld_data_reg;

    // ----------------------------------------
    // Array input gating
    // ----------------------------------------
    logic [5:0] pld_ctrl_reg;
    logic [5:0] pld_ctrl_next;

    assign pld_ctrl_next = {pld_clock_input_s & ~array_clk_off, pld_clock_input_s & ~mcell_clk_off,
                            mcu_wr & ~wr_off, mcu_rd & ~rd_off,
                            mcu_psen & ~psen_off, ale_in & ~ale_off};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pld_ctrl_reg <= '0;
        end else begin
            pld_ctrl_reg <= pld_ctrl_next;
        end
    end

    assign pld_array_clk = pld_ctrl_reg[5];
    assign pld_mcell_clk = pld_ctrl_reg[4];
    assign pld_wr = pld_ctrl_reg[3];
    assign pld_rd = pld_ctrl_reg[2];
    assign pld_psen = pld_ctrl_reg[1];
    assign pld_ale = pld_ctrl_reg[0];

    // ----------------------------------------
    // Turbo and battery indicator
    // ----------------------------------------
    logic battery_reg;

    assign pld_turbo_on = ~turbo_off;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            battery_reg <= 1'b0;
        end else begin
            battery_reg <= vbat_s & battery_indicator_route;
        end
    end

    assign battery_on_indicator = battery_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_COUNT_ADVANCE: assert property (
        apd_en && clk_tick && !exit_cond && !count_full |=> idle_count == $past(idle_count) + 4'h1)
        else $error("idle count did not advance");

    AST_PD_ENTRY: assert property (
        apd_en && count_full && !exit_cond && !powerdown_flag |=> powerdown_flag)
        else $error("powerdown not entered after full count");

    AST_ALE_EXIT: assert property (
        powerdown_flag && ale_edge |=> !powerdown_flag && idle_count == 4'h0)
        else $error("strobe activity did not exit powerdown");

    AST_CS_RESET_EXIT: assert property (
        (!csn_s || reset_s) |=> !powerdown_flag)
        else $error("select low or reset high left powerdown on");

    AST_PD_DESELECT: assert property (
        powerdown_flag |-> mem_sel == 4'h0 && $stable(mem_addr) && $stable(pld_data))
        else $error("bus not blocked during powerdown");

    AST_CLK_NOT_BLOCKED: assert property (
        array_clk_off && mcell_clk_off && apd_en && clk_tick && !exit_cond && !count_full
        |=> idle_count != 4'h0)
        else $error("clock blocking starved idle counter");

    AST_TURBO_WRITE: assert property (
        pmr_first_wr |=> pld_turbo_on == !$past(pmr_wdata[`APM_BIT_TURBO_OFF]))
        else $error("turbo bit write not applied");

    AST_CS_DISABLE: assert property (
        cs_high |=> mem_sel == 4'h0)
        else $error("memories selected while select high");

    AST_CS_PLD_RUNS: assert property (
        cs_high && !wr_off |=> pld_wr == $past(mcu_wr))
        else $error("select high blocked array strobe");

    AST_ALE_BLOCK: assert property (
        ale_off && !pmr_second_wr |=> !pld_ale)
        else $error("blocked strobe reached array");

    AST_REG_HOLD: assert property (
        reset_s && !pmr_first_wr && !pmr_second_wr |=> $stable(pmr_first_reg) && $stable(pmr_second_reg))
        else $error("reset input altered power mode registers");

    AST_DISABLED_IDLE: assert property (
        !apd_en |=> idle_count == 4'h0 && !powerdown_flag)
        else $error("disabled unit counted");

    COV_PD_ENTER: cover property (!powerdown_flag ##1 powerdown_flag);
    COV_ALE_WAKE: cover property (powerdown_flag && ale_edge ##1 !powerdown_flag);
    COV_CS_WAKE: cover property (powerdown_flag && !csn_s && !ale_edge);
    COV_BATTERY: cover property (battery_on_indicator);
endmodule : apm_auto_powerdown_manager
`default_nettype wire

/* File: logic/apm_idle_counter.sv */
`timescale 1ns/10ps
`default_nettype none
`include "apm_params.svh"
module apm_idle_counter (
    input wire logic clk,
    input wire logic rst,
    input wire logic restart,
    input wire logic tick,
    output apm_pkg::apm_count_t count,
    output logic full
);
    import apm_pkg::*;

    apm_count_t count_reg;
    apm_count_t count_next;

    // ----------------------------------------
    // Saturating idle counter
    // ----------------------------------------
    assign full = (count_reg == `APM_IDLE_LIMIT);
    assign count_next = restart ? '0 :
                        (tick && !full) ? count_reg + 4'h1 : count_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    assign count = count_reg;
endmodule : apm_idle_counter
`default_nettype wire

/* File: logic/apm_params.svh */
// What this block does
// - Idle counter runs once strobe stops toggling
// - Fifteen idle clock periods raise powerdown flag
// - Unit enable alone enables powerdown mode
// - Strobe activity resumes exits powerdown
// - Select low or reset high exits powerdown
// - Powerdown blocks bus, deselects all memories
// - Clock blocking bits never starve counter
// - Logic arrays and ports stay active
// - First register bit 3 turns turbo off
// - Turbo on until software sets bit
// - Select high disables memories and io block
// - Select high leaves logic arrays running
// - Blocking bits gate signals to arrays
// - Battery indicator while supply below standby
// - First register bit 1 enables unit
// - Bits 4 and 5 gate array clocks
// - Second register bits 2-5 gate strobes
// - Registers clear only at power-up
`ifndef APM_PARAMS_SVH
`define APM_PARAMS_SVH

`define APM_PMR_RESET 8'h00
`define APM_PMR_FIRST_MASK 8'h3A
`define APM_PMR_SECOND_MASK 8'h3C
`define APM_BIT_APD_EN 1
`define APM_BIT_TURBO_OFF 3
`define APM_BIT_ARRAY_CLK_OFF 4
`define APM_BIT_MCELL_CLK_OFF 5
`define APM_BIT_WR_OFF 2
`define APM_BIT_RD_OFF 3
`define APM_BIT_PSEN_OFF 4
`define APM_BIT_ALE_OFF 5
`define APM_IDLE_LIMIT 4'hF
`define APM_TURBO_MARGIN_MHZ 5
`define APM_SEL_PRIMARY 0
`define APM_SEL_SECONDARY 1
`define APM_SEL_SRAM 2
`define APM_SEL_IO 3

`endif

/* File: logic/apm_pkg.sv */
package apm_pkg;
    typedef logic [3:0] apm_count_t;
    typedef logic [7:0] apm_byte_t;
    typedef logic [3:0] apm_sel_t;
    typedef enum logic {APM_NORMAL, APM_POWERDOWN} apm_mode_e;
endpackage : apm_pkg

/* File: logic/apm_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module apm_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    // ----------------------------------------
    // Two flop synchroniser
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
        end
    end

    assign sync_out = stage2_reg;
endmodule : apm_sync
`default_nettype wire

/* File: test/apm_mcu_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ------------------------------
// Bus strobe model of the MCU
// ------------------------------
module apm_mcu_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    output logic ale,
    output logic wr,
    output logic rd,
    output logic psen
);
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    // Clock margin external
    // No clock is made here; the turbo-off rate is a board duty
    assign cnt_next = run ? cnt_reg + 4'h1 : cnt_reg;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= 4'h0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
    assign ale = cnt_reg[0];
    assign wr = cnt_reg[1];
    assign rd = cnt_reg[2];
    assign psen = cnt_reg[3];
endmodule : apm_mcu_model
`default_nettype wire

/* File: test/test_auto_powerdown_manager.sv */
`timescale 1ns/10ps
`default_nettype none
module test_auto_powerdown_manager;
    import apm_pkg::*;
    typedef struct {int id; logic [15:0] v;} apm_note_s;
    logic clk, rst, pclk, csn, rin, vlow, route, run, w1, w2;
    wire logic ale, wr, rd, psen;
    logic [15:0] addr, ma, pa;
    logic [7:0] data, md, pd, wd;
    apm_sel_t req, ms;
    logic flag, ac, mc, pw, pr, pp, pl, turbo, bat;
    apm_count_t cnt;
    apm_byte_t r1, r2;
    int miscompares, n_tests;
    logic [31:0] seed;
    apm_note_s q[$];
    string nm[17] = '{"flag", "count", "reg1", "reg2", "mem_addr", "mem_sel", "pld_addr", "turbo", "battery",
        "array_clk", "mcell_clk", "pld_wr", "pld_rd", "pld_psen", "pld_ale", "mem_data", "pld_data"};
    // ------------------------------
    // Design and partner
    // ------------------------------
    apm_auto_powerdown_manager apm_auto_powerdown_manager_i (.clk(clk), .rst(rst), .pld_clock_input(pclk),
        .chip_select_n_pin(csn), .reset_in_pin(rin), .vcc_below_standby(vlow), .battery_indicator_route(route),
        .ale_in(ale), .mcu_wr(wr), .mcu_rd(rd), .mcu_psen(psen), .mcu_addr(addr), .mcu_data(data),
        .mem_sel_req(req), .pmr_first_wr(w1), .pmr_second_wr(w2), .pmr_wdata(wd), .powerdown_flag(flag),
        .idle_count(cnt), .power_mode_reg_first(r1), .power_mode_reg_second(r2), .mem_addr(ma), .mem_data(md),
        .mem_sel(ms), .pld_addr(pa), .pld_data(pd), .pld_array_clk(ac), .pld_mcell_clk(mc), .pld_wr(pw),
        .pld_rd(pr), .pld_psen(pp), .pld_ale(pl), .pld_turbo_on(turbo), .battery_on_indicator(bat));
    apm_mcu_model apm_mcu_model_i (.clk(clk), .rst(rst), .run(run), .ale(ale), .wr(wr), .rd(rd), .psen(psen));
    // ------------------------------
    // Helpers
    // ------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    function automatic logic [15:0] obs(int id);
        case (id)
            0: return {15'h0000, flag};
            1: return {12'h000, cnt};
            2: return {8'h00, r1};
            3: return {8'h00, r2};
            4: return ma;
            5: return {12'h000, ms};
            6: return pa;
            7: return {15'h0000, turbo};
            8: return {15'h0000, bat};
            9: return {15'h0000, ac};
            10: return {15'h0000, mc};
            11: return {15'h0000, pw};
            12: return {15'h0000, pr};
            13: return {15'h0000, pp};
            14: return {15'h0000, pl};
            15: return {8'h00, md};
            default: return {8'h00, pd};
        endcase
    endfunction : obs
    task automatic check(string n, logic [15:0] seen, logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask : check
    task automatic note(int id, logic [15:0] v);
        q.push_back('{id, v});
    endtask : note
    task automatic cyc(int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic wreg(bit sec, logic [7:0] v);
        @(negedge clk);
        w1 = !sec;
        w2 = sec;
        wd = v;
        @(negedge clk);
        w1 = 1'b0;
        w2 = 1'b0;
    endtask : wreg
    task automatic edges(int n);
        repeat (n) begin
            pclk = 1'b1;
            cyc(4);
            pclk = 1'b0;
            cyc(4);
        end
    endtask : edges
    task automatic strobes(logic [7:0] b);
        logic [3:0] s;
        run = 1'b1;
        s = {ale, psen, rd, wr};
        @(negedge clk);
        note(11, s[0] & !b[2]);
        note(12, s[1] & !b[3]);
        note(13, s[2] & !b[4]);
        note(14, s[3] & !b[5]);
        run = 1'b0;
    endtask : strobes
    task automatic enter(logic [7:0] v);
        pclk = 1'b0;
        run = 1'b0;
        csn = 1'b1;
        cyc(3);
        wreg(0, v);
        edges(14);
        note(1, 16'h000E);
        note(0, 16'h0000);
        edges(1);
        note(0, 16'h0001);
        note(1, 16'h000F);
    endtask : enter
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish
    // ------------------------------
    // Clock, watcher, watchdog
    // ------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = !clk;
    end
    initial begin : watch
        apm_note_s e;
        forever begin
            wait (q.size() != 0);
            e = q.pop_front();
            check(nm[e.id], obs(e.id), e.v);
        end
    end
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        tally_and_finish();
    end
    // ------------------------------
    // Scenarios
    // ------------------------------
    initial begin
        logic [31:0] v;
        logic [15:0] a0;
        logic [7:0] d0;
        seed = 32'h00012761;
        {pclk, csn, rin, vlow, route, run, w1, w2} = 8'h00;
        addr = 16'h0000;
        data = 8'h00;
        req = 4'hF;
        wd = 8'h00;
        rst = 1'b1;
        cyc(2);
        rst = 1'b0;
        cyc(1);
        note(7, 16'h0001);
        note(2, 16'h0000);
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 32'hFFFF : xs();
            pclk = v[9];
            addr = v[31:16];
            data = v[7:0];
            wreg(0, v[7:0]);
            note(2, {8'h00, v[7:0] & 8'h3A});
            note(7, !v[3]);
            note(4, v[31:16]);
            note(15, {8'h00, v[7:0]});
            note(16, {8'h00, v[7:0]});
            wreg(1, v[15:8]);
            note(3, {8'h00, v[15:8] & 8'h3C});
            note(9, pclk & !v[4]);
            note(10, pclk & !v[5]);
            strobes(v[15:8]);
        end
        for (int i = 0; i < 4; i++) begin
            vlow = i[0];
            route = i[1];
            cyc(4);
            note(8, i == 3);
        end
        wreg(1, 8'h00);
        note(5, 16'h000F);
        csn = 1'b1;
        cyc(4);
        note(5, 16'h0000);
        strobes(8'h00);
        wreg(0, 8'h00);
        edges(16);
        note(1, 16'h0000);
        note(0, 16'h0000);
        enter(8'h32);
        csn = 1'b0;
        cyc(4);
        note(0, 16'h0000);
        note(1, 16'h0000);
        enter(8'h02);
        a0 = ma;
        d0 = md;
        v = xs();
        addr = v[31:16];
        data = v[7:0];
        cyc(2);
        note(4, a0);
        note(6, a0);
        note(15, {8'h00, d0});
        note(16, {8'h00, d0});
        pclk = 1'b1;
        cyc(4);
        note(9, 16'h0001);
        pclk = 1'b0;
        cyc(4);
        run = 1'b1;
        cyc(2);
        note(0, 16'h0000);
        note(1, 16'h0000);
        note(4, addr);
        note(15, {8'h00, data});
        enter(8'h02);
        rin = 1'b1;
        cyc(4);
        note(0, 16'h0000);
        note(2, 16'h0002);
        rin = 1'b0;
        cyc(2);
        tally_and_finish();
    end
endmodule : test_auto_powerdown_manager
`default_nettype wire
